// ### core/ldsl_core.sv
// ldsl_core: shift register, data register, error-detection mode and sink control
// assumes serial_clk, load_strobe, output_enable_n and serial_in are sampled synchronously to clk
//
// Behaviour
// [RULE1] 16-bit shift register plus 16-bit data register
// [RULE2] serial clock rise shifts serial input in
// [RULE3] first received bit ends up as MSB
// [RULE4] data in at serial_in, out at serial_out
// [RULE5] load strobe rise copies shift register over
// [RULE6] enable low drives sinks from data register
// [RULE7] one sink output per data register bit
// [RULE8] error mode: load fall captures fault data
// [RULE9] serial out, load, enable carry diagnostics
// [RULE10] temperature always, open/short any time checked; the core checks open/short only on channels whose data_reg bit is 1
// [RULE11] controller holds enable high 2000 ns first; the model holds output_enable_n low 2000 ns before its rise
// [RULE12] load rise with enable high, clock low enters
// [RULE13] error status captured at enable rising edge
// [RULE14] pulse count selects test; flag low on error
// [RULE15] controller clocks out sixteen bits per device
// [RULE16] serial out shows last shift position bit
`timescale 1ns/1ps
module ldsl_core
	import ldsl_pkg::*;
(
	// clock, reset, enable
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	// serial pins
	input  wire logic        serial_clk,
	input  wire logic        serial_in,
	input  wire logic        load_strobe,
	input  wire logic        output_enable_n,
	output logic             serial_out,
	// analog fault comparators
	input  wire ldsl_fault_t fault_in,
	// sink drive and status
	output logic [15:0]      led_sink_output,
	output logic             low_current_mode,
	output logic             shutdown_mode
);
	// ----------------------------------------------------------------
	// edge detection
	// ----------------------------------------------------------------
	logic        sclk_reg, ld_reg, oen_reg;
	logic        sclk_rise, ld_rise, ld_fall, oen_rise;
	ldsl_mode_t  mode_reg;
	logic [15:0] shift_reg, data_reg;
	logic [2:0]  sel_reg;
	ldsl_fault_t fault_reg;
	logic        gflag;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sclk_reg <= 1'b0;
			ld_reg   <= 1'b0;
			oen_reg  <= 1'b1;
		end else if (clk_en) begin
			sclk_reg <= serial_clk;
			ld_reg   <= load_strobe;
			oen_reg  <= output_enable_n;
		end
	end
	assign sclk_rise = serial_clk & ~sclk_reg;
	assign ld_rise   = load_strobe & ~ld_reg;
	assign ld_fall   = ~load_strobe & ld_reg;
	assign oen_rise  = output_enable_n & ~oen_reg;

	// ----------------------------------------------------------------
	// two-entry buffer between shift register and data register
	// ----------------------------------------------------------------
	// a load request is queued so a busy latch stage never drops a word
	ldsl_word_t  buf_mem [2];
	logic        buf_wptr, buf_rptr;
	logic [1:0]  buf_cnt;
	logic        buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;

	assign buf_in_valid  = ld_rise & (mode_reg == LDSL_NORMAL);
	assign buf_in_ready  = (buf_cnt != 2'h2);
	assign buf_out_valid = (buf_cnt != 2'h0);
	// the latch stage never stalls, so the buffer holds at most one word between two load edges
	assign buf_out_ready = 1'b1;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			buf_wptr   <= 1'b0;
			buf_rptr   <= 1'b0;
			buf_cnt    <= 2'h0;
			buf_mem[0] <= '0;
			buf_mem[1] <= '0;
		end else if (clk_en) begin
			if (buf_in_valid && buf_in_ready) begin
				buf_mem[buf_wptr].word <= shift_reg;
				buf_wptr               <= ~buf_wptr;
			end
			if (buf_out_valid && buf_out_ready)
				buf_rptr <= ~buf_rptr;
			buf_cnt <= buf_cnt + 2'(buf_in_valid && buf_in_ready) - 2'(buf_out_valid && buf_out_ready);
		end
	end

	// ----------------------------------------------------------------
	// mode control
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mode_reg <= LDSL_NORMAL;
		end else if (clk_en) begin
			case (mode_reg)
				LDSL_NORMAL: begin
					if (ld_rise && output_enable_n && !serial_clk)
						mode_reg <= LDSL_ERRDET; // RULE12
				end
				LDSL_ERRDET: begin
					// leaving through load low with enable low on this and the previous sample ends the diagnostic cycle
					if (!output_enable_n && !load_strobe && oen_reg == 1'b0)
						mode_reg <= LDSL_NORMAL;
				end
				default: mode_reg <= LDSL_NORMAL;
			endcase
		end
	end

	// pulse count selects the global error function
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sel_reg <= LDSL_SEL_RST;
		end else if (clk_en) begin
			if (ld_rise && output_enable_n && !serial_clk && mode_reg == LDSL_NORMAL)
				sel_reg <= LDSL_SEL_RST;
			else if (mode_reg == LDSL_ERRDET && sclk_rise && load_strobe && sel_reg != LDSL_SEL_SHUTDOWN)
				sel_reg <= sel_reg + 3'h1; // RULE14
		end
	end

	// status caught on the enable rising edge
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fault_reg <= '1;
		end else if (clk_en && oen_rise) begin
			fault_reg.overtemp_flag <= fault_in.overtemp_flag; // RULE13 RULE10
			fault_reg.open_led_flag  <= fault_in.open_led_flag | ~data_reg;
			fault_reg.short_led_flag <= fault_in.short_led_flag | ~data_reg;
		end
	end

	always_comb begin
		case (sel_reg)
			LDSL_SEL_TEMP:  gflag = fault_reg.overtemp_flag;
			LDSL_SEL_OPEN:  gflag = &fault_reg.open_led_flag;
			LDSL_SEL_SHORT: gflag = &fault_reg.short_led_flag;
			default:        gflag = 1'b1;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			low_current_mode <= 1'b0;
			shutdown_mode    <= 1'b0;
		end else if (clk_en) begin
			low_current_mode <= (mode_reg == LDSL_ERRDET) && (sel_reg == LDSL_SEL_LOWCUR);
			if (mode_reg == LDSL_ERRDET && sel_reg == LDSL_SEL_SHUTDOWN && ld_fall)
				shutdown_mode <= ~serial_in;
		end
	end

	// ----------------------------------------------------------------
	// shift register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shift_reg <= LDSL_SHIFT_RST;
		end else if (clk_en) begin
			if (mode_reg == LDSL_ERRDET && ld_fall) begin
				case (sel_reg) // RULE8
					LDSL_SEL_OPEN:  shift_reg <= fault_reg.open_led_flag;
					LDSL_SEL_SHORT: shift_reg <= fault_reg.short_led_flag;
					default:        shift_reg <= {15'h7fff, fault_reg.overtemp_flag} & (~LDSL_TEMP_BIT | {15'h0000, fault_reg.overtemp_flag});
				endcase
			end else if (sclk_rise) begin
				shift_reg <= {shift_reg[14:0], serial_in}; // RULE1 RULE2 RULE3
			end
		end
	end

	// ----------------------------------------------------------------
	// data register and sinks
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			data_reg <= LDSL_DATA_RST;
		end else if (clk_en && buf_out_valid && buf_out_ready) begin
			data_reg <= buf_mem[buf_rptr].word; // RULE5
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			led_sink_output <= LDSL_SINK_OFF;
			serial_out      <= 1'b0;
		end else if (clk_en) begin
			led_sink_output <= output_enable_n ? LDSL_SINK_OFF : data_reg; // RULE6 RULE7
			// in global error mode the flag is gated with the chain input
			if (mode_reg == LDSL_ERRDET && load_strobe)
				serial_out <= gflag & serial_in; // RULE9
			else
				serial_out <= shift_reg[15]; // RULE4 RULE16
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence load_edge_s;
		ld_rise && mode_reg == LDSL_NORMAL && clk_en && !(output_enable_n && !serial_clk);
	endsequence

	shift_step_a: assert property (@(posedge clk) disable iff (!nrst) // RULE2
		(clk_en && sclk_rise && !ld_fall) |=> shift_reg == {$past(shift_reg[14:0]), $past(serial_in)})
		else $error("shift step wrong");
	load_copy_a: assert property (@(posedge clk) disable iff (!nrst) // RULE5
		(load_edge_s and buf_cnt == 2'h0) ##1 clk_en |=> data_reg == $past(shift_reg, 2))
		else $error("data register not loaded");
	sink_drive_a: assert property (@(posedge clk) disable iff (!nrst) // RULE6
		(clk_en && !output_enable_n) |=> led_sink_output == $past(data_reg))
		else $error("sinks not following data");
	sink_off_a: assert property (@(posedge clk) disable iff (!nrst) // RULE6
		(clk_en && output_enable_n) |=> led_sink_output == 16'h0000)
		else $error("sinks on while disabled");
	chain_out_a: assert property (@(posedge clk) disable iff (!nrst) // RULE16
		(clk_en && mode_reg == LDSL_NORMAL) |=> serial_out == $past(shift_reg[15]))
		else $error("serial out not last bit");
	mode_enter_a: assert property (@(posedge clk) disable iff (!nrst) // RULE12
		(clk_en && mode_reg == LDSL_NORMAL && ld_rise && output_enable_n && !serial_clk) |=> mode_reg == LDSL_ERRDET)
		else $error("error mode not entered");
	fault_cap_a: assert property (@(posedge clk) disable iff (!nrst) // RULE8
		(clk_en && mode_reg == LDSL_ERRDET && ld_fall && sel_reg == LDSL_SEL_OPEN) |=> shift_reg == $past(fault_reg.open_led_flag))
		else $error("fault data not captured");
	temp_cap_a: assert property (@(posedge clk) disable iff (!nrst) // RULE13
		(clk_en && oen_rise) |=> fault_reg.overtemp_flag == $past(fault_in.overtemp_flag))
		else $error("status not acquired");
endmodule // ldsl_core

// ### inc/ldsl_pkg.sv
// ldsl_pkg: constants and carrier types for the led driver shift/latch core
// assumes a single 250 MHz clock domain; all pins are pre-synchronised
package ldsl_pkg;
	// ----------------------------------------------------------------
	// sizes and reset values
	// ----------------------------------------------------------------
	localparam int           LDSL_WIDTH     = 16;
	localparam logic [15:0]  LDSL_SHIFT_RST = 16'h0000;
	localparam logic [15:0]  LDSL_DATA_RST  = 16'h0000;
	localparam logic [15:0]  LDSL_SINK_OFF  = 16'h0000;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int           LDSL_CLK_PERIOD_NS = 4;
	localparam int           LDSL_TESTING_NS    = 2000;
	localparam int           LDSL_TESTING_CYC   = (LDSL_TESTING_NS + LDSL_CLK_PERIOD_NS - 1) / LDSL_CLK_PERIOD_NS;
	// ----------------------------------------------------------------
	// global error selection by clock pulse count
	// ----------------------------------------------------------------
	localparam logic [2:0]   LDSL_SEL_TEMP     = 3'h0;
	localparam logic [2:0]   LDSL_SEL_OPEN     = 3'h1;
	localparam logic [2:0]   LDSL_SEL_SHORT    = 3'h2;
	localparam logic [2:0]   LDSL_SEL_LOWCUR   = 3'h3;
	localparam logic [2:0]   LDSL_SEL_SHUTDOWN = 3'h4;
	localparam logic [2:0]   LDSL_SEL_RST      = 3'h0;
	localparam logic [15:0]  LDSL_TEMP_BIT     = 16'h0001;

	typedef enum logic [1:0] {
		LDSL_NORMAL = 2'b01,
		LDSL_ERRDET = 2'b10
	} ldsl_mode_t;

	// per-channel open/short and single overtemp fault status from analog comparators, low means fault
	typedef struct packed {
		logic [15:0] open_led_flag;
		logic [15:0] short_led_flag;
		logic        overtemp_flag;
	} ldsl_fault_t;

	// buffered shift word toward the data register
	typedef struct packed {
		logic [15:0] word;
	} ldsl_word_t;
endpackage

// ### bench/ldsl_ctrl_model.sv
// ldsl_ctrl_model: display controller driving the serial pins of one driver
// assumes clk is the core clock; pins change on its falling edge, 2 clk per level
`timescale 1ns/1ps
module ldsl_ctrl_model (
	// core clock and returning serial data
	input  wire logic clk,
	input  wire logic serial_out,
	// serial pins toward the driver
	output logic      serial_clk,
	output logic      serial_in,
	output logic      load_strobe,
	output logic      output_enable_n
);
	initial begin
		serial_clk      = 1'b0;
		serial_in       = 1'b1;
		load_strobe     = 1'b0;
		output_enable_n = 1'b1;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask
	// the bit seen is taken before each rise, so it is the one about to leave
	task automatic send_word(input logic [15:0] w, output logic [15:0] seen);
		for (int i = 15; i >= 0; i--) begin
			serial_in = w[i];
			hold(2);
			seen[i] = serial_out;
			serial_clk = 1'b1;
			hold(2);
			serial_clk = 1'b0;
		end
		serial_in = ~w[0];
	endtask
	task automatic strobe(input logic lvl);
		load_strobe = lvl;
		hold(2);
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			serial_clk = 1'b1;
			hold(2);
			serial_clk = 1'b0;
			hold(2);
		end
	endtask
	// enable stays high and clock low around the entering load rise
	task automatic enter_err();
		output_enable_n = 1'b1;
		hold(2);
		strobe(1'b1);
	endtask
	task automatic test_window();
		output_enable_n = 1'b0;
		hold(500);
		output_enable_n = 1'b1;
		hold(2);
	endtask
endmodule // ldsl_ctrl_model

// ### bench/led_driver_shift_latch_tb.sv
// led_driver_shift_latch_tb: scenarios for the shift/latch core
// assumes ldsl_ctrl_model drives the serial pins; faults driven here
`timescale 1ns/1ps
module led_driver_shift_latch_tb;
	import ldsl_pkg::*;
	logic        clk;
	logic        nrst;
	logic        clk_en;
	logic        serial_clk;
	logic        serial_in;
	logic        load_strobe;
	logic        output_enable_n;
	logic        serial_out;
	ldsl_fault_t fault_in;
	logic [15:0] led_sink_output;
	logic        low_current_mode;
	logic        shutdown_mode;
	logic [15:0] seen;
	int          error_cnt = 0;
	int          n_checks = 0;
	always #2 clk = ~clk;
	ldsl_core i_ldsl_core (.clk(clk), .nrst(nrst), .clk_en(clk_en), .serial_clk(serial_clk),
		.serial_in(serial_in), .load_strobe(load_strobe), .output_enable_n(output_enable_n),
		.serial_out(serial_out), .fault_in(fault_in), .led_sink_output(led_sink_output),
		.low_current_mode(low_current_mode), .shutdown_mode(shutdown_mode));
	ldsl_ctrl_model i_ldsl_ctrl_model (.clk(clk), .serial_out(serial_out), .serial_clk(serial_clk),
		.serial_in(serial_in), .load_strobe(load_strobe), .output_enable_n(output_enable_n));
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic t_load_chain();
		i_ldsl_ctrl_model.output_enable_n = 1'b0;
		i_ldsl_ctrl_model.send_word(16'ha5c3, seen);
		chk("reset shift", seen, LDSL_SHIFT_RST);
		i_ldsl_ctrl_model.strobe(1'b1);
		i_ldsl_ctrl_model.strobe(1'b0);
		chk("sinks on", led_sink_output, 16'ha5c3);
		i_ldsl_ctrl_model.output_enable_n = 1'b1;
		i_ldsl_ctrl_model.hold(4);
		chk("sinks off", led_sink_output, LDSL_SINK_OFF);
		i_ldsl_ctrl_model.send_word(16'h1234, seen);
		chk("chain out", seen, 16'ha5c3);
		$display("done load_chain");
	endtask
	// n pulses pick the test; the entering load rise also latches the shifted word, so each
	// report shifts in a5c3: open faults on channel 1 (lit) and 2 (dark), short on 6 (lit) and 5 (dark)
	task automatic t_err(input int n, input logic [15:0] rep);
		fault_in.open_led_flag = 16'hfff9;
		fault_in.short_led_flag = 16'hff9f;
		fault_in.overtemp_flag = 1'b0;
		i_ldsl_ctrl_model.serial_in = 1'b1;
		i_ldsl_ctrl_model.enter_err();
		i_ldsl_ctrl_model.pulses(n);
		i_ldsl_ctrl_model.test_window();
		chk("global flag", {15'h0, serial_out}, 16'h0000);
		i_ldsl_ctrl_model.strobe(1'b0);
		i_ldsl_ctrl_model.output_enable_n = 1'b0;
		i_ldsl_ctrl_model.send_word(16'ha5c3, seen);
		chk("report", seen, rep);
		fault_in = '1;
		$display("done err_sel %0d", n);
	endtask
	task automatic t_modes();
		i_ldsl_ctrl_model.enter_err();
		i_ldsl_ctrl_model.pulses(3);
		chk("low current", {15'h0, low_current_mode}, 16'h0001);
		i_ldsl_ctrl_model.pulses(1);
		i_ldsl_ctrl_model.serial_in = 1'b0;
		i_ldsl_ctrl_model.strobe(1'b0);
		i_ldsl_ctrl_model.hold(2);
		chk("shutdown", {15'h0, shutdown_mode}, 16'h0001);
		$display("done modes");
	endtask
	// mid-run reset out of error mode, then a word shifted while the clock enable is low is lost
	task automatic t_freeze_reset();
		nrst = 1'b0;
		i_ldsl_ctrl_model.hold(4);
		chk("reset shutdown", {15'h0, shutdown_mode}, 16'h0000);
		nrst = 1'b1;
		i_ldsl_ctrl_model.output_enable_n = 1'b0;
		clk_en = 1'b0;
		i_ldsl_ctrl_model.send_word(16'hffff, seen);
		chk("frozen shift", seen, LDSL_SHIFT_RST);
		clk_en = 1'b1;
		i_ldsl_ctrl_model.hold(2);
		i_ldsl_ctrl_model.strobe(1'b1);
		i_ldsl_ctrl_model.strobe(1'b0);
		chk("frozen load", led_sink_output, LDSL_SHIFT_RST);
		$display("done freeze_reset");
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		clk_en = 1'b1;
		fault_in = '1;
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		t_load_chain();
		t_err(0, 16'hfffe);
		t_err(1, 16'hfffd);
		t_err(2, 16'hffbf);
		t_modes();
		t_freeze_reset();
		wrap_up();
	end
endmodule // led_driver_shift_latch_tb
